// file: verilog/palette_pkg.sv
package palette_pkg;

    // ------------------------------------------------------------
    // Register select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_PAL_WR_PTR  = 3'h0;
    localparam logic [2:0] SEL_PAL_DATA    = 3'h1;
    localparam logic [2:0] SEL_PIXEL_MASK  = 3'h2;
    localparam logic [2:0] SEL_PAL_RD_PTR  = 3'h3;
    localparam logic [2:0] SEL_OVL_WR_PTR  = 3'h4;
    localparam logic [2:0] SEL_OVL_DATA    = 3'h5;
    localparam logic [2:0] SEL_RESERVED    = 3'h6;
    localparam logic [2:0] SEL_OVL_RD_PTR  = 3'h7;

    // ------------------------------------------------------------
    // Component sub-counter values
    // ------------------------------------------------------------
    localparam logic [1:0] COMP_RED   = 2'h0;
    localparam logic [1:0] COMP_GREEN = 2'h1;
    localparam logic [1:0] COMP_BLUE  = 2'h2;

    // ------------------------------------------------------------
    // Sizes, reset values and timing
    // ------------------------------------------------------------
    localparam int         PALETTE_DEPTH   = 256;
    localparam int         OVERLAY_DEPTH   = 16;
    localparam int         SYNC_STAGES     = 2;
    localparam logic [7:0] POINTER_RESET   = 8'h00;
    localparam logic [1:0] COMP_RESET      = 2'h0;
    localparam logic [7:0] MASK_RESET      = 8'hFF;
    localparam logic [7:0] POINTER_STEP    = 8'h01;
    localparam logic [3:0] OVERLAY_NONE    = 4'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } rgb_t;

    typedef struct packed {
        logic [7:0] index;
        logic [3:0] overlay;
        logic       sync_n;
        logic       blank_n;
        logic       pedestal;
    } pixel_in_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        logic       sync_n;
        logic       blank_n;
        logic       pedestal;
    } video_out_t;

endpackage

// file: verilog/strobe_sync.sv
`timescale 1ns/10ps
`default_nettype none

module strobe_sync #(
    parameter int STAGES = 2,
    parameter int WIDTH  = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Strobes
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // Flop chain, idle level high
    // ------------------------------------------------------------
    logic [WIDTH-1:0] chain_reg [0:STAGES-1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                chain_reg[i] <= '1;
            end
        end else begin
            chain_reg[0] <= async_in;
            for (int i = 1; i < STAGES; i++) begin
                chain_reg[i] <= chain_reg[i-1];
            end
        end
    end

    assign sync_out = chain_reg[STAGES-1];

endmodule

`default_nettype wire

// file: verilog/palette_lookup.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Loading pointer in overlay read mode fetches that overlay entry, then advances.
// - Host reads red, green, blue; after blue, refetch next entry and advance.
// - Palette blue access at location FF wraps pointer to zero.
// - Overlay access uses low pointer nibble; nibble zero is reserved.
// - Host bus is asynchronous; transfers happen internally between host accesses.
// - Two-bit modulo-three counter selects red, green, blue for each cycle.
// - Counter clears on pointer write, not on pointer read, hidden from host.
// - Eight pointer bits count binary, incrementing after a blue cycle or a read-mode pointer load.
// - Pointer read allowed anytime, changes neither pointer nor mode.
// - Width select high means eight-bit colour, low means six-bit.
// - Six-bit colour on bits 0..5; bits 6,7 ignored on write, zero on read.
// - Eight-bit colour uses all data bits, bit 0 least significant.
// - Six-bit mode forces two converter LSBs to zero.
// - Pixel index is ANDed with mask before lookup; mask accessible anytime.
// - Zero overlay select uses masked palette; nonzero selects overlay colour.
// - Selected entry gives a 24-bit word split across three channels.
// - Sync and blank captured with colour on rising pixel clock, same stage.
// - Blank forces blank level; sync removes offset; both high passes data.
// - Pedestal select low gives zero, high 7.5 IRE; no-overlay variant zero.
// - Select decode: 000,011,001,010,100,111,101 as documented, 110 reserved.
// - After blue write, store the three components at pointer, then advance.
// - Loading pointer in palette read mode fetches entry, then advances.
module palette_lookup
    import palette_pkg::*;
#(
    parameter int HAS_OVERLAY   = 1,
    parameter int SIX_BIT_ONLY  = 0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Host bus
    input  wire logic              host_wr_n,
    input  wire logic              host_rd_n,
    input  wire logic [2:0]        register_select,
    input  wire logic [7:0]        host_data_in,
    output logic      [7:0]        host_data_out,
    output logic                   host_data_oe_n,
    input  wire logic              width_8bit,
    // Frame buffer
    input  wire logic [7:0]        pixel_index,
    input  wire logic [3:0]        overlay_select,
    input  wire logic              sync_n,
    input  wire logic              blank_n,
    input  wire logic              pedestal_sel,
    // Converters
    output palette_pkg::video_out_t video_out
);
    import palette_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] from_bus(input logic [7:0] d, input logic w8);
        from_bus = w8 ? d : {d[5:0], 2'b00};
    endfunction

    function automatic logic [7:0] to_bus(input logic [7:0] c, input logic w8);
        to_bus = w8 ? c : {2'b00, c[7:2]};
    endfunction

    function automatic logic is_ptr_sel(input logic [2:0] s);
        is_ptr_sel = (s == SEL_PAL_WR_PTR) || (s == SEL_PAL_RD_PTR) ||
                     (s == SEL_OVL_WR_PTR) || (s == SEL_OVL_RD_PTR);
    endfunction

    function automatic logic is_data_sel(input logic [2:0] s);
        is_data_sel = (s == SEL_PAL_DATA) || (s == SEL_OVL_DATA);
    endfunction

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    rgb_t       palette_mem [0:PALETTE_DEPTH-1];
    rgb_t       overlay_mem [0:OVERLAY_DEPTH-1];
    rgb_t       hold_reg;
    logic [7:0] ptr_reg;
    logic [1:0] comp_reg;
    logic [7:0] mask_reg;
    logic [7:0] wr_data_reg;
    logic [2:0] wr_sel_reg;
    logic [2:0] rd_sel_reg;
    logic [7:0] data_out_reg;
    logic [1:0] strobe_s;
    logic [1:0] strobe_d_reg;
    pixel_in_t  pix_reg;
    video_out_t video_reg;
    logic       w8;

    assign w8 = width_8bit && (SIX_BIT_ONLY == 0);

    // ------------------------------------------------------------
    // Strobe crossing
    // ------------------------------------------------------------
    // Pins are sampled directly, but effects wait for the synchronised end
    // of the strobe, so storage only moves between host accesses.
    strobe_sync #(
        .STAGES   (SYNC_STAGES),
        .WIDTH    (2)
    ) u_strobe_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({host_rd_n, host_wr_n}),
        .sync_out (strobe_s)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strobe_d_reg <= 2'h3;
        end else begin
            strobe_d_reg <= strobe_s;
        end
    end

    logic wr_end;
    logic rd_end;
    assign wr_end = strobe_s[0] && !strobe_d_reg[0];
    assign rd_end = strobe_s[1] && !strobe_d_reg[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_data_reg <= 8'h00;
            wr_sel_reg  <= SEL_RESERVED;
            rd_sel_reg  <= SEL_RESERVED;
        end else begin
            if (!host_wr_n) begin
                wr_data_reg <= host_data_in;
                wr_sel_reg  <= register_select;
            end
            if (!host_rd_n) begin
                rd_sel_reg <= register_select;
            end
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic       ptr_load;
    logic       ptr_load_rd;
    logic       wr_data;
    logic       rd_data;
    logic       blue_wr;
    logic       blue_rd;
    logic [7:0] fetch_loc;
    logic       fetch_ovl;
    rgb_t       fetch_word;
    rgb_t       store_word;

    assign ptr_load    = wr_end && is_ptr_sel(wr_sel_reg);
    assign ptr_load_rd = ptr_load && wr_sel_reg[0] && wr_sel_reg[1];
    assign wr_data     = wr_end && is_data_sel(wr_sel_reg);
    assign rd_data     = rd_end && is_data_sel(rd_sel_reg);
    assign blue_wr     = wr_data && (comp_reg == COMP_BLUE);
    assign blue_rd     = rd_data && (comp_reg == COMP_BLUE);
    assign fetch_loc   = ptr_load_rd ? wr_data_reg : ptr_reg;
    assign fetch_ovl   = ptr_load_rd ? wr_sel_reg[2] : rd_sel_reg[2];
    assign store_word  = '{hold_reg.red, hold_reg.green, from_bus(wr_data_reg, w8)};

    always_comb begin
        if (fetch_ovl) begin
            fetch_word = overlay_mem[fetch_loc[3:0]];
        end else begin
            fetch_word = palette_mem[fetch_loc];
        end
    end

    // ------------------------------------------------------------
    // Pointer and component counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg  <= POINTER_RESET;
            comp_reg <= COMP_RESET;
        end else if (ptr_load) begin
            ptr_reg  <= ptr_load_rd ? 8'(wr_data_reg + POINTER_STEP) : wr_data_reg;
            comp_reg <= COMP_RED;
        end else if (wr_data || rd_data) begin
            if (comp_reg == COMP_BLUE) begin
                comp_reg <= COMP_RED;
                ptr_reg  <= 8'(ptr_reg + POINTER_STEP);
            end else begin
                comp_reg <= 2'(comp_reg + 2'h1);
            end
        end
    end

    // ------------------------------------------------------------
    // Colour holding registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= '0;
        end else if (ptr_load_rd || blue_rd) begin
            hold_reg <= fetch_word;
        end else if (wr_data) begin
            case (comp_reg)
                COMP_RED: begin
                    hold_reg.red <= from_bus(wr_data_reg, w8);
                end
                COMP_GREEN: begin
                    hold_reg.green <= from_bus(wr_data_reg, w8);
                end
                default: begin
                    hold_reg.blue <= from_bus(wr_data_reg, w8);
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Palette and overlay storage
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < PALETTE_DEPTH; i++) begin
                palette_mem[i] <= '0;
            end
        end else if (blue_wr && !wr_sel_reg[2]) begin
            palette_mem[ptr_reg] <= store_word;
        end
    end

    // Entry zero is never written, so reserved overlay reads return zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < OVERLAY_DEPTH; i++) begin
                overlay_mem[i] <= '0;
            end
        end else if (blue_wr && wr_sel_reg[2] && (ptr_reg[3:0] != OVERLAY_NONE)) begin
            overlay_mem[ptr_reg[3:0]] <= store_word;
        end
    end

    // ------------------------------------------------------------
    // Pixel mask
    // ------------------------------------------------------------
    // Reset value is a safe pass-all; software still initialises it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_reg <= MASK_RESET;
        end else if (wr_end && (wr_sel_reg == SEL_PIXEL_MASK)) begin
            mask_reg <= wr_data_reg;
        end
    end

    // ------------------------------------------------------------
    // Host read data
    // ------------------------------------------------------------
    logic [7:0] comp_value;

    always_comb begin
        case (comp_reg)
            COMP_RED:   comp_value = hold_reg.red;
            COMP_GREEN: comp_value = hold_reg.green;
            default:    comp_value = hold_reg.blue;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out_reg <= 8'h00;
        end else if (is_ptr_sel(register_select)) begin
            data_out_reg <= ptr_reg;
        end else if (is_data_sel(register_select)) begin
            data_out_reg <= to_bus(comp_value, w8);
        end else if (register_select == SEL_PIXEL_MASK) begin
            data_out_reg <= mask_reg;
        end else begin
            data_out_reg <= 8'h00;
        end
    end

    assign host_data_out  = data_out_reg;
    assign host_data_oe_n = host_rd_n;

    // ------------------------------------------------------------
    // Pixel pipeline
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pix_reg <= '{8'h00, OVERLAY_NONE, 1'b1, 1'b0, 1'b0};
        end else begin
            pix_reg <= '{pixel_index, overlay_select, sync_n, blank_n, pedestal_sel};
        end
    end

    rgb_t       pix_colour;
    logic [7:0] low_mask;

    assign low_mask = w8 ? 8'hFF : 8'hFC;

    always_comb begin
        if ((HAS_OVERLAY != 0) && (pix_reg.overlay != OVERLAY_NONE)) begin
            pix_colour = overlay_mem[pix_reg.overlay];
        end else begin
            pix_colour = palette_mem[pix_reg.index & mask_reg];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            video_reg <= '{8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0};
        end else if (!pix_reg.blank_n) begin
            video_reg <= '{8'h00, 8'h00, 8'h00, pix_reg.sync_n, 1'b0,
                           pix_reg.pedestal && (HAS_OVERLAY != 0)};
        end else begin
            video_reg <= '{pix_colour.red & low_mask, pix_colour.green & low_mask,
                           pix_colour.blue & low_mask, pix_reg.sync_n, 1'b1,
                           pix_reg.pedestal && (HAS_OVERLAY != 0)};
        end
    end

    assign video_out = video_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ptr_write_clears;
        @(posedge clk) disable iff (!arst_n)
        wr_end && (wr_sel_reg == SEL_PAL_WR_PTR) |=> (ptr_reg == $past(wr_data_reg)) && (comp_reg == COMP_RED);
    endproperty
    a_ptr_write_clears: assert property (p_ptr_write_clears)
        else $error("pointer write did not load pointer and clear counter");

    property p_blue_advance;
        @(posedge clk) disable iff (!arst_n)
        blue_wr |=> (comp_reg == COMP_RED) && (ptr_reg == 8'($past(ptr_reg) + POINTER_STEP));
    endproperty
    a_blue_advance: assert property (p_blue_advance)
        else $error("blue write did not advance pointer");

    property p_wrap;
        @(posedge clk) disable iff (!arst_n)
        blue_rd && !rd_sel_reg[2] && (ptr_reg == 8'hFF) |=> (ptr_reg == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("pointer did not wrap to zero");

    property p_component_step;
        @(posedge clk) disable iff (!arst_n)
        (wr_data || rd_data) && !ptr_load && (comp_reg != COMP_BLUE)
            |=> $stable(ptr_reg) && (comp_reg == 2'($past(comp_reg) + 2'h1));
    endproperty
    a_component_step: assert property (p_component_step)
        else $error("component counter stepped wrongly");

    property p_ptr_read_stable;
        @(posedge clk) disable iff (!arst_n)
        rd_end && is_ptr_sel(rd_sel_reg) && !wr_end |=> $stable(ptr_reg) && $stable(comp_reg);
    endproperty
    a_ptr_read_stable: assert property (p_ptr_read_stable)
        else $error("pointer read disturbed pointer state");

    property p_reserved_quiet;
        @(posedge clk) disable iff (!arst_n)
        wr_end && (wr_sel_reg == SEL_RESERVED) && !rd_end
            |=> $stable(ptr_reg) && $stable(comp_reg) && $stable(mask_reg) && $stable(hold_reg);
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet)
        else $error("reserved access changed state");

    property p_read_load_advance;
        @(posedge clk) disable iff (!arst_n)
        ptr_load_rd |=> (ptr_reg == 8'($past(wr_data_reg) + POINTER_STEP)) && (comp_reg == COMP_RED);
    endproperty
    a_read_load_advance: assert property (p_read_load_advance)
        else $error("read-mode pointer load did not advance");

    property p_strobe_latency;
        @(posedge clk) disable iff (!arst_n)
        $rose(host_wr_n) |-> ##2 wr_end;
    endproperty
    a_strobe_latency: assert property (p_strobe_latency)
        else $error("write strobe end not seen after synchroniser delay");

    property p_blank_level;
        @(posedge clk) disable iff (!arst_n)
        !blank_n |=> ##1 !video_out.blank_n && (video_out.red == 8'h00) && (video_out.blue == 8'h00);
    endproperty
    a_blank_level: assert property (p_blank_level)
        else $error("blank did not force blank level two cycles later");

    property p_six_bit_lsbs;
        @(posedge clk) disable iff (!arst_n)
        !width_8bit |=> (video_out.red[1:0] == 2'b00) && (video_out.green[1:0] == 2'b00);
    endproperty
    a_six_bit_lsbs: assert property (p_six_bit_lsbs)
        else $error("six-bit mode left converter LSBs set");

endmodule

`default_nettype wire

// file: bench/palette_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module palette_host_model (
    // Clock
    input  wire logic       clk,
    // Host bus
    output logic            host_wr_n,
    output logic            host_rd_n,
    output logic      [2:0] register_select,
    output logic      [7:0] host_data_in,
    input  wire logic [7:0] host_data_out
);
    initial begin
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        register_select = 3'h0;
        host_data_in = 8'h00;
    end

    // ------------------------------------------------------------
    // One bus cycle
    // ------------------------------------------------------------
    // Strobe low two cycles, idle six so the synchronised effect lands
    task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clk);
        register_select = sel;
        host_data_in = d;
        if (wr) begin
            host_wr_n = 1'b0;
        end else begin
            host_rd_n = 1'b0;
        end
        repeat (2) @(negedge clk);
        q = host_data_out;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        // Released bus shows no stale value
        host_data_in = ~d;
        repeat (6) @(negedge clk);
    endtask
endmodule

`default_nettype wire

// file: bench/palette_lookup_tb.sv
`timescale 1ns/10ps
`default_nettype none

module palette_lookup_tb;
    import palette_pkg::*;
    logic       clk = 1'b0;
    logic       arst_n, width_8bit, sync_n, blank_n, pedestal_sel;
    logic [7:0] pixel_index, q, mask;
    logic [3:0] overlay_select;
    wire        host_wr_n, host_rd_n, host_data_oe_n;
    wire  [2:0] register_select;
    wire  [7:0] host_data_in, host_data_out;
    video_out_t video_out;
    rgb_t       pal [2];
    rgb_t       ovl, got, c6;
    int         err_total, comparisons;

    always #10 clk = ~clk;

    palette_lookup palette_lookup_i (.clk(clk), .arst_n(arst_n), .host_wr_n(host_wr_n),
        .host_rd_n(host_rd_n), .register_select(register_select),
        .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe_n(host_data_oe_n), .width_8bit(width_8bit),
        .pixel_index(pixel_index), .overlay_select(overlay_select), .sync_n(sync_n),
        .blank_n(blank_n), .pedestal_sel(pedestal_sel), .video_out(video_out));

    palette_host_model palette_host_model_i (.clk(clk), .host_wr_n(host_wr_n),
        .host_rd_n(host_rd_n), .register_select(register_select),
        .host_data_in(host_data_in), .host_data_out(host_data_out));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic rgb_t low6(input rgb_t v);
        return {2'h0, v.red[5:0], 2'h0, v.green[5:0], 2'h0, v.blue[5:0]};
    endfunction

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        palette_host_model_i.access(1'b1, sel, d, q);
    endtask

    task automatic rd(input logic [2:0] sel);
        palette_host_model_i.access(1'b0, sel, 8'h00, q);
    endtask

    task automatic wr_rgb(input logic [2:0] sel, input rgb_t v);
        wr(sel, v.red);
        wr(sel, v.green);
        wr(sel, v.blue);
    endtask

    task automatic rd_rgb(input logic [2:0] sel);
        rd(sel);
        got.red = q;
        rd(sel);
        got.green = q;
        rd(sel);
        got.blue = q;
    endtask

    task automatic px(input logic [7:0] idx, input logic [3:0] ov, input rgb_t exp);
        @(negedge clk);
        pixel_index = idx;
        overlay_select = ov;
        sync_n = 1'($urandom);
        pedestal_sel = 1'($urandom);
        repeat (2) @(negedge clk);
        chk({video_out.red, video_out.green, video_out.blue}, exp);
        chk({21'h0, video_out.sync_n, video_out.blank_n, video_out.pedestal},
            {21'h0, sync_n, blank_n, pedestal_sel});
    endtask

    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        width_8bit = 1'b1;
        pixel_index = 8'h00;
        overlay_select = 4'h0;
        sync_n = 1'b1;
        blank_n = 1'b0;
        pedestal_sel = 1'b0;
        err_total = 0;
        comparisons = 0;
        void'($urandom(32'h6AC03A9F));
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        wr(SEL_PIXEL_MASK, 8'hFF);
        // Block fill across the top of the palette, inside blanking
        wr(SEL_PAL_WR_PTR, 8'hFE);
        for (int i = 0; i < 2; i++) begin
            pal[i] = rgb_t'($urandom);
            wr_rgb(SEL_PAL_DATA, pal[i]);
        end
        rd(SEL_PAL_WR_PTR);
        chk({16'h0, q}, 24'h000000);
        wr(SEL_PAL_RD_PTR, 8'hFE);
        rd(SEL_PAL_RD_PTR);
        chk({16'h0, q}, 24'h0000FF);
        for (int i = 0; i < 2; i++) begin
            rd_rgb(SEL_PAL_DATA);
            chk(got, pal[i]);
        end
        rd(SEL_PAL_RD_PTR);
        chk({16'h0, q}, 24'h000001);
        // Masked lookup; only bit 0 of the mask picks between the two entries
        mask = {7'h7F, 1'($urandom)};
        wr(SEL_PIXEL_MASK, mask);
        // Bus driver enabled only while the read strobe is low
        fork
            rd(SEL_PIXEL_MASK);
            begin
                repeat (2) @(negedge clk);
                chk({23'h0, host_data_oe_n}, 24'h000000);
            end
        join
        chk({23'h0, host_data_oe_n}, 24'h000001);
        chk({16'h0, q}, {16'h0, mask});
        blank_n = 1'b1;
        px(8'hFF, OVERLAY_NONE, pal[mask[0]]);
        // Overlay: upper pointer nibble must not matter
        ovl = rgb_t'($urandom);
        wr(SEL_OVL_WR_PTR, 8'h13);
        wr_rgb(SEL_OVL_DATA, ovl);
        wr(SEL_OVL_RD_PTR, 8'h23);
        rd_rgb(SEL_OVL_DATA);
        chk(got, ovl);
        px(8'hFF, 4'h3, ovl);
        blank_n = 1'b0;
        px(8'hFF, 4'h3, 24'h000000);
        blank_n = 1'b1;
        // Reserved code touches nothing and reads zero
        wr(SEL_RESERVED, 8'h5A);
        rd(SEL_RESERVED);
        chk({16'h0, q}, 24'h000000);
        rd(SEL_OVL_RD_PTR);
        chk({16'h0, q}, 24'h000025);
        // Six-bit transfers; pointer read mid-entry must keep the count
        width_8bit = 1'b0;
        c6 = rgb_t'($urandom);
        wr(SEL_PIXEL_MASK, 8'hFF);
        wr(SEL_PAL_WR_PTR, 8'h05);
        wr(SEL_PAL_DATA, c6.red);
        rd(SEL_PAL_WR_PTR);
        chk({16'h0, q}, 24'h000005);
        wr(SEL_PAL_DATA, c6.green);
        wr(SEL_PAL_DATA, c6.blue);
        wr(SEL_PAL_RD_PTR, 8'h05);
        rd_rgb(SEL_PAL_DATA);
        chk(got, low6(c6));
        px(8'h05, OVERLAY_NONE, low6(c6) << 2);
        finish_test();
    end
endmodule

`default_nettype wire
